// ==== rtl/sdct_params.svh ====
`ifndef SDCT_PARAMS_SVH
`define SDCT_PARAMS_SVH
// Clock periods in ns
`define SDCT_SYS_PERIOD_NS    40
`define SDCT_LINK_PERIOD_NS   80
// Timing minimums in ns, the last two in clock cycles
`define SDCT_RAS_NS           35
`define SDCT_WR_NS            15
`define SDCT_RFC_NS           160
`define SDCT_REFPDEN_NS       40
`define SDCT_XPDLL_NS         24
`define SDCT_XPDLL_CK         10
`define SDCT_WR_DLLOFF_CK     4
// Refresh interval in ns
`define SDCT_REFI_NS          7812
`define SDCT_REF_BURST        9
`define SDCT_REF_WIN_NS       70300
// Write recovery start offsets after write latency
`define SDCT_WRS_FULL         4
`define SDCT_WRS_CHOP         2
// Clock divider half period for the link clock
`define SDCT_LINK_DIV         1
`define SDCT_RESET_HOLD       8
`endif

// ==== rtl/sdct_pkg.sv ====
package sdct_pkg;
  typedef enum logic [2:0] {
    SDCT_NOP, SDCT_ACT, SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE, SDCT_WR, SDCT_WRAP, SDCT_REF, SDCT_PREA
  } sdct_cmd_t;
  typedef enum logic [1:0] {
    SDCT_BURST_LEN_EIGHT, SDCT_BURST_CHOP_FOUR, SDCT_ON_THE_FLY_SELECT
  } sdct_burst_t;
  // Round-up and round-down conversions of ns to cycles
  function automatic int sdct_ru(input int ns, input int per);
    int r;
    r = (ns + per - 1) / per;
    return (r < 1) ? 1 : r;
  endfunction
  function automatic int sdct_rd(input int ns, input int per);
    int r;
    r = ns / per;
    return (r < 1) ? 1 : r;
  endfunction
endpackage

// ==== rtl/sdct_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sdct_if;
  logic                link_clk;
  logic                device_reset_low;
  logic                clock_enable_pin;
  sdct_pkg::sdct_cmd_t cmd;
  logic [2:0]          bank;
  logic                chop;
  logic                strobe_window;
  logic                wr_recovery_start;
  modport ctrl (output link_clk, device_reset_low, clock_enable_pin, cmd, bank, chop,
                input strobe_window, wr_recovery_start);
  modport dev  (input link_clk, device_reset_low, clock_enable_pin, cmd, bank, chop,
                output strobe_window, wr_recovery_start);
endinterface
`default_nettype wire

// ==== rtl/sdct_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdct_params.svh"
module sdct_device #(
  parameter int READ_LATENCY  = 5,
  parameter int ADD_LATENCY   = 0,
  parameter int WRITE_LATENCY = 5
) (
  // Link
  sdct_if.dev                link,
  // Configuration and status
  input  wire logic          dll_disabled,
  input  wire sdct_pkg::sdct_burst_t burst_mode,
  output logic [7:0]         bank_open,
  output logic [7:0]         precharge_done
);
  import sdct_pkg::*;
  localparam int RAS_CK = sdct_ru(`SDCT_RAS_NS, `SDCT_LINK_PERIOD_NS);
  localparam int WR_CK  = sdct_ru(`SDCT_WR_NS, `SDCT_LINK_PERIOD_NS);
  localparam int WRD_CK = (WR_CK > `SDCT_WR_DLLOFF_CK) ? WR_CK : `SDCT_WR_DLLOFF_CK;
  localparam int SKEW_AT = READ_LATENCY + ADD_LATENCY - 1;
  localparam int WRS_MAX = WRITE_LATENCY + `SDCT_WRS_FULL;
  // Pipe slots: a set slot reaches bit 0 one edge before its pulse
  localparam int RD_POS  = (SKEW_AT < 2) ? 0 : SKEW_AT - 1;
  localparam int WR_FULL = WRS_MAX - 1;
  localparam int WR_CHOP = WRITE_LATENCY + `SDCT_WRS_CHOP - 1;
  typedef struct packed {
    logic [1:0]      rst_sync;
    logic [1:0]      dll_sync;
    logic [7:0]      open;
    logic [7:0]      ap_pend;
    logic [7:0]      done;
    logic [7:0][7:0] ras_cnt;
    logic [15:0]     rd_pipe;
    logic [15:0]     wr_pipe;
    logic [2:0]      wr_bank;
    logic            strobe;
    logic            wrs;
  } sdct_dev_t;
  sdct_dev_t st;
  sdct_dev_t next_st;
  always_comb begin
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], link.device_reset_low};
    next_st.dll_sync = {st.dll_sync[0], dll_disabled};
    // Pipes keep every pending pulse when commands overlap
    next_st.rd_pipe  = st.rd_pipe >> 1;
    next_st.wr_pipe  = st.wr_pipe >> 1;
    // Skew window opens RL+AL-1 after read, only while DLL disabled
    next_st.strobe   = st.rd_pipe[0] & st.dll_sync[1];
    next_st.wrs      = st.wr_pipe[0];
    next_st.done     = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (st.ras_cnt[b] != 8'h00) begin
        next_st.ras_cnt[b] = st.ras_cnt[b] - 8'h01;
      end
      // Auto precharge held until row active time met
      if (st.ap_pend[b] && st.ras_cnt[b] == 8'h00) begin
        next_st.ap_pend[b] = 1'b0;
        next_st.open[b]    = 1'b0;
        next_st.done[b]    = 1'b1;
      end
    end
    if (link.clock_enable_pin) begin
      case (link.cmd)
        SDCT_ACT: begin
          next_st.open[link.bank]    = 1'b1;
          next_st.ras_cnt[link.bank] = 8'(RAS_CK - 1);
        end
        SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE: begin
          next_st.rd_pipe[RD_POS] = 1'b1;
          if (link.cmd == SDCT_READ_WITH_AUTOPRECHARGE) next_st.ap_pend[link.bank] = 1'b1;
        end
        SDCT_WR, SDCT_WRAP: begin
          // Recovery start: WL+4, or WL+2 for fixed chop
          if (burst_mode == SDCT_BURST_CHOP_FOUR) begin
            next_st.wr_pipe[WR_CHOP] = 1'b1;
          end else begin
            next_st.wr_pipe[WR_FULL] = 1'b1;
          end
          if (link.cmd == SDCT_WRAP) next_st.ap_pend[link.bank] = 1'b1;
        end
        SDCT_PREA: begin
          next_st.open    = 8'h00;
          next_st.ap_pend = 8'h00;
        end
        default: begin
        end
      endcase
    end
    if (!st.rst_sync[1]) begin
      next_st.open    = 8'h00;
      next_st.ap_pend = 8'h00;
      next_st.rd_pipe = 16'h0000;
      next_st.wr_pipe = 16'h0000;
      next_st.ras_cnt = '0;
      next_st.done    = 8'h00;
      next_st.strobe  = 1'b0;
      next_st.wrs     = 1'b0;
    end
  end
  always_ff @(posedge link.link_clk) begin
    st <= next_st;
  end
  assign link.strobe_window     = st.strobe;
  assign link.wr_recovery_start = st.wrs;
  assign bank_open              = st.open;
  assign precharge_done         = st.done;
endmodule
`default_nettype wire

// ==== rtl/sdct_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdct_params.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module sdct_ctrl #(
  parameter int REFI_CK = sdct_pkg::sdct_rd(`SDCT_REFI_NS, `SDCT_SYS_PERIOD_NS)
) (
  // System
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // User requests
  input  wire logic                req_valid,
  input  wire sdct_pkg::sdct_cmd_t req_cmd,
  input  wire logic [2:0]          req_bank,
  input  wire logic                req_chop,
  input  wire logic                hot,
  input  wire logic                dll_disabled,
  input  wire logic                latency_change,
  input  wire logic                powerdown_req,
  output logic                     req_ready,
  output logic                     in_powerdown,
  // Link
  sdct_if.ctrl                     link
);
  import sdct_pkg::*;
  // Cycles counted on sys_clk; ns minimums rounded up
  localparam int RAS_CK = sdct_ru(`SDCT_RAS_NS, `SDCT_SYS_PERIOD_NS);
  localparam int WR_CK  = sdct_ru(`SDCT_WR_NS, `SDCT_SYS_PERIOD_NS);
  localparam int WRD_CK = (WR_CK > `SDCT_WR_DLLOFF_CK) ? WR_CK : `SDCT_WR_DLLOFF_CK;
  localparam int XP_CK0 = sdct_ru(`SDCT_XPDLL_NS, `SDCT_SYS_PERIOD_NS);
  localparam int XP_CK  = (XP_CK0 > `SDCT_XPDLL_CK) ? XP_CK0 : `SDCT_XPDLL_CK;
  localparam int RFC_CK = sdct_ru(`SDCT_RFC_NS, `SDCT_SYS_PERIOD_NS);
  localparam int RPD_CK = sdct_ru(`SDCT_REFPDEN_NS, `SDCT_SYS_PERIOD_NS);
  localparam int LINKSCALE = `SDCT_LINK_PERIOD_NS / `SDCT_SYS_PERIOD_NS;
  typedef struct packed {
    logic [3:0]      rst_cnt;
    logic            div;
    logic            link_edge;
    logic            cke;
    logic [15:0]     refi;
    logic [3:0]      owed;
    logic [7:0]      xp;
    logic [7:0]      rfc;
    logic [7:0]      rpd;
    logic            prea_due;
    logic [7:0][7:0] ras;
    logic [7:0][7:0] wr;
    sdct_cmd_t       cmd;
    logic [2:0]      bank;
    logic            chop;
  } sdct_ctrl_t;
  sdct_ctrl_t st;
  sdct_ctrl_t next_st;
  logic       busy;
  logic       reads;
  function automatic logic [7:0] sdct_dec(input logic [7:0] v);
    return (v != 8'h00) ? v - 8'h01 : 8'h00;
  endfunction
  always_comb begin
    reads = (req_cmd == SDCT_RD) || (req_cmd == SDCT_READ_WITH_AUTOPRECHARGE);
    // Locked-DLL wait, refresh spacing, bank counters
    busy  = (reads && st.xp != 8'h00) || (st.rfc != 8'h00) || st.prea_due
            || (req_cmd == SDCT_PREA && (st.ras[req_bank] != 8'h00 || st.wr[req_bank] != 8'h00))
            || (st.rst_cnt != 4'h0) || !st.cke;
  end
  assign req_ready = st.link_edge && !busy && (st.owed == 4'h0 || req_cmd == SDCT_REF);
  always_comb begin
    next_st = st;
    next_st.div       = ~st.div;
    next_st.link_edge = ~st.div;
    if (st.rst_cnt != 4'h0) next_st.rst_cnt = st.rst_cnt - 4'h1;
    next_st.xp  = sdct_dec(st.xp);
    next_st.rfc = sdct_dec(st.rfc);
    next_st.rpd = sdct_dec(st.rpd);
    for (int b = 0; b < 8; b++) begin
      next_st.ras[b] = sdct_dec(st.ras[b]);
      next_st.wr[b]  = sdct_dec(st.wr[b]);
    end
    // Refresh interval, halved when hot
    if (st.refi == 16'h0000) begin
      next_st.refi = hot ? 16'(REFI_CK / 2 - 1) : 16'(REFI_CK - 1);
      // Owed count capped so nine fit the window
      if (st.owed < 4'(`SDCT_REF_BURST - 1)) next_st.owed = st.owed + 4'h1;
    end else begin
      next_st.refi = st.refi - 16'h0001;
    end
    // Latency change reloads locked exit delay
    if (latency_change) next_st.xp = 8'(XP_CK);
    if (st.link_edge) begin
      next_st.cmd = SDCT_NOP;
      if (st.prea_due && st.rfc == 8'h00) begin
        // Slow clock rate: precharge-all follows refresh
        next_st.cmd      = SDCT_PREA;
        next_st.prea_due = 1'b0;
      end else if (!st.cke) begin
        if (!powerdown_req) begin
          next_st.cke = 1'b1;
          next_st.xp  = 8'(XP_CK);
        end
      end else if (powerdown_req && st.rpd == 8'h00 && st.rfc == 8'h00 && st.xp == 8'h00) begin
        // Power-down after refresh spacing and exit delay
        next_st.cke = 1'b0;
      end else if (st.owed != 4'h0 && st.rfc == 8'h00 && st.rst_cnt == 4'h0) begin
        // Owed refresh issued ahead of user requests
        next_st.cmd      = SDCT_REF;
        next_st.rfc      = 8'(RFC_CK);
        next_st.rpd      = 8'(RPD_CK);
        next_st.prea_due = (`SDCT_SYS_PERIOD_NS * LINKSCALE > `SDCT_SYS_PERIOD_NS);
        next_st.owed     = st.owed - 4'h1;
      end else if (req_valid && req_ready) begin
        next_st.cmd  = req_cmd;
        next_st.bank = req_bank;
        next_st.chop = req_chop;
        case (req_cmd)
          SDCT_ACT: next_st.ras[req_bank] = 8'(RAS_CK);
          SDCT_WR, SDCT_WRAP: begin
            // DLL-off recovery uses larger of 4CK and 15ns
            next_st.wr[req_bank] = dll_disabled ? 8'(WRD_CK * LINKSCALE) : 8'(WR_CK);
          end
          SDCT_REF: begin
            next_st.rfc      = 8'(RFC_CK);
            next_st.rpd      = 8'(RPD_CK);
            next_st.prea_due = (`SDCT_SYS_PERIOD_NS * LINKSCALE > `SDCT_SYS_PERIOD_NS);
            if (st.owed != 4'h0) next_st.owed = st.owed - 4'h1;
          end
          default: begin
          end
        endcase
      end
    end
    if (sys_rst) begin
      next_st          = '0;
      next_st.rst_cnt  = 4'(`SDCT_RESET_HOLD);
      next_st.cke      = 1'b1;
      next_st.cmd      = SDCT_NOP;
      next_st.refi     = 16'(REFI_CK - 1);
    end
  end
  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end
  // Reset held low until hold count expires
  assign link.device_reset_low = (st.rst_cnt == 4'h0);
  assign link.link_clk         = st.div;
  assign link.clock_enable_pin = st.cke;
  assign link.cmd              = st.cmd;
  assign link.bank             = st.bank;
  assign link.chop             = st.chop;
  assign in_powerdown          = !st.cke;
endmodule
`default_nettype wire

// ==== test/sdct_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdct_chk #(
  parameter int READ_LATENCY  = 5,
  parameter int ADD_LATENCY   = 0,
  parameter int WRITE_LATENCY = 5
) (
  // Link
  input wire logic                link_clk,
  input wire logic                device_reset_low,
  input wire logic                clock_enable_pin,
  input wire sdct_pkg::sdct_cmd_t cmd,
  input wire logic [2:0]          bank,
  input wire logic                chop,
  input wire logic                strobe_window,
  input wire logic                wr_recovery_start
);
  import sdct_pkg::*;
  // Window opens RL+AL-1 edges after the read, seen one edge later
  localparam int RS_DLY = READ_LATENCY + ADD_LATENCY;
  localparam int WS_MIN = WRITE_LATENCY + 2;
  localparam int WS_MAX = WRITE_LATENCY + 5;
  logic [9:0] ref_gap;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!device_reset_low);
  //----------------------------------------
  // Link cycles since last refresh or power-down
  //----------------------------------------
  always_ff @(posedge link_clk) begin
    if (!device_reset_low || cmd == SDCT_REF || !clock_enable_pin) begin
      ref_gap <= 10'h000;
    end else if (ref_gap != 10'h3ff) begin
      ref_gap <= ref_gap + 10'h001;
    end
  end
  //----------------------------------------
  // Assertions
  //----------------------------------------
  a_ref_no_repeat: assert property (cmd == SDCT_REF |=> cmd != SDCT_REF)
    else $error("refresh repeated on next link cycle");
  a_ref_then_prea: assert property (cmd == SDCT_REF |-> ##[1:4] cmd == SDCT_PREA)
    else $error("no precharge-all after refresh");
  a_ref_cke_hold: assert property (cmd == SDCT_REF |=> clock_enable_pin)
    else $error("clock enable dropped right after refresh");
  a_strobe_cause: assert property (strobe_window |-> $past(cmd, RS_DLY) inside {SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE})
    else $error("strobe window not tied to a read");
  a_write_recovery: assert property (cmd inside {SDCT_WR, SDCT_WRAP} |-> ##[WS_MIN:WS_MAX] wr_recovery_start)
    else $error("write recovery start missing");
  a_lock_before_read: assert property ($rose(clock_enable_pin) |-> !(cmd inside {SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE}) [*5])
    else $error("read too soon after power-down exit");
  a_refresh_gap: assert property (ref_gap < 10'h12c)
    else $error("refresh postponed too long");
  a_cke_idle: assert property (!clock_enable_pin |-> cmd == SDCT_NOP)
    else $error("command issued in power-down");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdct_pkg::*;
  localparam int RL = 5;
  localparam int AL = 0;
  localparam int WL = 5;
  localparam int REFI = 50;
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        req_valid = 1'h0;
  sdct_cmd_t   req_cmd = SDCT_NOP;
  logic [2:0]  req_bank = 3'h0;
  logic        req_chop = 1'h0;
  logic        hot = 1'h0;
  logic        dll_off = 1'h0;
  logic        lat_chg = 1'h0;
  logic        pd_req = 1'h0;
  sdct_burst_t bmode = SDCT_BURST_LEN_EIGHT;
  logic        req_ready;
  logic        in_pd;
  int          fails = 0;
  int          num_checks = 0;
  int          lc = 0;
  int          nref = 0;
  int          rd_lq[$];
  int          wr_lq[$];
  int          exp_rs[$];
  int          exp_wrs[$];
  logic [6:0]  exp_cmd[$];
  sdct_cmd_t   ops[5] = '{SDCT_ACT, SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE, SDCT_WR, SDCT_WRAP};
  sdct_if sdct_if_i();
  sdct_ctrl #(.REFI_CK(REFI)) sdct_ctrl_i(.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_chop(req_chop), .hot(hot), .dll_disabled(dll_off),
    .latency_change(lat_chg), .powerdown_req(pd_req), .req_ready(req_ready), .in_powerdown(in_pd), .link(sdct_if_i));
  sdct_device #(.READ_LATENCY(RL), .ADD_LATENCY(AL), .WRITE_LATENCY(WL)) sdct_device_i(.link(sdct_if_i),
    .dll_disabled(dll_off), .burst_mode(bmode), .bank_open(), .precharge_done());
  sdct_chk #(.READ_LATENCY(RL), .ADD_LATENCY(AL), .WRITE_LATENCY(WL)) sdct_chk_i(.link_clk(sdct_if_i.link_clk),
    .device_reset_low(sdct_if_i.device_reset_low), .clock_enable_pin(sdct_if_i.clock_enable_pin), .cmd(sdct_if_i.cmd),
    .bank(sdct_if_i.bank), .chop(sdct_if_i.chop), .strobe_window(sdct_if_i.strobe_window),
    .wr_recovery_start(sdct_if_i.wr_recovery_start));
  always #20 sys_clk = ~sys_clk;
  //----------------------------------------
  // Shared tasks
  //----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic send(input sdct_cmd_t c, input logic [2:0] b, input logic ch);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_cmd <= c;
    req_bank <= b;
    req_chop <= ch;
    exp_cmd.push_back({c, b, ch});
    if (c inside {SDCT_WR, SDCT_WRAP}) exp_wrs.push_back((bmode == SDCT_BURST_CHOP_FOUR) ? WL + 2 : WL + 4);
    if (c inside {SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE} && dll_off) exp_rs.push_back(RL + AL - 1);
    do begin
      @(negedge sys_clk);
      n++;
    end while (req_ready !== 1'h1 && n < 400);
    if (n >= 400) fails++;
    @(posedge sys_clk);
    req_valid <= 1'h0;
  endtask
  //----------------------------------------
  // Link monitor
  //----------------------------------------
  always @(posedge sdct_if_i.link_clk) begin
    #1;
    lc = lc + 1;
    if (sdct_if_i.cmd == SDCT_REF) nref++;
    if (!(sdct_if_i.cmd inside {SDCT_NOP, SDCT_REF, SDCT_PREA})) begin
      check({sdct_if_i.cmd, sdct_if_i.bank, sdct_if_i.chop}, exp_cmd.size() ? exp_cmd.pop_front() : 7'h7f);
      if (sdct_if_i.cmd inside {SDCT_RD, SDCT_READ_WITH_AUTOPRECHARGE} && dll_off) rd_lq.push_back(lc);
      if (sdct_if_i.cmd inside {SDCT_WR, SDCT_WRAP}) wr_lq.push_back(lc);
    end
    if (sdct_if_i.strobe_window)
      check(rd_lq.size() ? lc - rd_lq.pop_front() : -1, exp_rs.size() ? exp_rs.pop_front() : -2);
    if (sdct_if_i.wr_recovery_start)
      check(wr_lq.size() ? lc - wr_lq.pop_front() : -1, exp_wrs.size() ? exp_wrs.pop_front() : -2);
  end
  //----------------------------------------
  // Main sequence and watchdog
  //----------------------------------------
  initial begin
    void'($urandom(51));
    repeat (10) @(negedge sys_clk);
    check(sdct_if_i.device_reset_low, 1'h0);
    @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
    check(sdct_if_i.device_reset_low, 1'h0);
    for (int m = 0; m < 6; m++) begin
      @(posedge sys_clk);
      bmode <= sdct_burst_t'(m % 3);
      dll_off <= (m >= 3);
      repeat (10) @(posedge sys_clk);
      repeat (6) send(ops[$urandom % 5], 3'($urandom), 1'($urandom));
      repeat (40) @(posedge sys_clk);
    end
    lat_chg <= 1'h1;
    @(posedge sys_clk);
    lat_chg <= 1'h0;
    send(SDCT_RD, 3'h2, 1'h0);
    pd_req <= 1'h1;
    repeat (60) @(negedge sys_clk);
    check({in_pd, sdct_if_i.clock_enable_pin}, 2'h2);
    @(posedge sys_clk);
    pd_req <= 1'h0;
    send(SDCT_READ_WITH_AUTOPRECHARGE, 3'h5, 1'h0);
    for (int h = 0; h < 2; h++) begin
      @(posedge sys_clk);
      hot <= h[0];
      repeat (100) @(posedge sys_clk);
      nref = 0;
      repeat (1000) @(posedge sys_clk);
      check(nref >= (1 + h) * 1000 / REFI - 1 && nref <= (1 + h) * 1000 / REFI + 1, 1'h1);
    end
    repeat (50) @(posedge sys_clk);
    check(exp_cmd.size() + exp_rs.size() + exp_wrs.size(), 0);
    test_done();
  end
  initial begin
    #(40 * 20000);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
